/* hdl/pep_defs.vh */
// Purpose: constants for the per-port end-to-end parity error unit
// Assumes: 32-bit avalon-mm register slave, byte addresses
// Notes: included by the parity unit module, not by the parity generator
`ifndef PEP_DEFS_VH
`define PEP_DEFS_VH

`define PEP_ADDR_CTL 12'h740
`define PEP_ADDR_STS 12'h744
`define PEP_ADDR_RPT 12'h748
`define PEP_ADDR_CNT 12'h74C
`define PEP_ADDR_IRQ_STS 12'h760
`define PEP_ADDR_IRQ_MASK 12'h764

`define PEP_CTL_DIS_BIT 0
`define PEP_CTL_INJ_BIT 1
`define PEP_CTL_LEN_LO 8
`define PEP_CTL_LEN_HI 15
`define PEP_STS_FLAG_BIT 0
`define PEP_RPT_RESET 2'h2
`define PEP_CNT_MAX 8'hFF

`define PEP_MSG_NONE 2'h0
`define PEP_MSG_COR 2'h1
`define PEP_MSG_NONFATAL 2'h2
`define PEP_MSG_FATAL 2'h3

`define PEP_IRQ_ERR_BIT 0
`define PEP_IRQ_SAT_BIT 1
`define PEP_IRQ_W 2

`endif

/* hdl/pep_parity_gen.v */
// Purpose: per-byte even parity for one data word, with optional inversion
// Assumes: word width is a multiple of eight
// Notes: parity output is registered along with the data
module pep_parity_gen
#(
    parameter DW = 32
)
(
    input wire clk,
    input wire rstN,
    input wire inValid,
    input wire [DW-1:0] inData,
    input wire corrupt,
    output reg outValid,
    output reg [DW-1:0] outData,
    output reg [DW/8-1:0] outPar
);
    wire [DW/8-1:0] par;

    // one parity bit per byte lane
    genvar g;
    generate
        for (g = 0; g < DW/8; g = g + 1)
        begin : lane
            assign par[g] = ^inData[g*8+7:g*8] ^ corrupt;
        end
    endgenerate

    // register data and parity together so they stay aligned
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            outValid <= 1'b0;
            outData <= {DW{1'b0}};
            outPar <= {(DW/8){1'b0}};
        end
        else
        begin
            outValid <= inValid;
            outData <= inData;
            outPar <= par;
        end
    end
endmodule

/* hdl/pep_parity_unit.v */
// Purpose: per-port end-to-end parity generation, checking and error reporting
// Assumes: avalon-mm slave with waitrequest; tx/rx word streams from the port and core
// Notes: sticky fields reset only on fundamental reset (fundRstN)
//
// Chosen here: register access over Avalon-MM.
`include "pep_defs.vh"
module pep_parity_unit
#(
    parameter DW = 32
)
(
    input wire clk,
    input wire rst_n,
    input wire fundRstN,
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire avs_waitrequest,
    output reg [31:0] avs_readdata,
    output reg avs_response,
    input wire txValid,
    input wire txSop,
    input wire [DW-1:0] txData,
    output wire coreValid,
    output wire [DW-1:0] coreData,
    output wire [DW/8-1:0] corePar,
    input wire rxValid,
    input wire [DW-1:0] rxData,
    input wire [DW/8-1:0] rxPar,
    output reg errMsgValid,
    output reg [1:0] errMsgType,
    output wire irq
);
    // reset release through two flops; both resets asserted async
    reg [1:0] rstSync_q;
    reg [1:0] fundSync_q;
    wire rstN = rstSync_q[1];
    wire fundN = fundSync_q[1];

    // hot or link reset: clears non-sticky state only
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync_q <= 2'h0;
        end
        else
        begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end


    always @(posedge clk or negedge fundRstN)
    begin
        // fundamental reset: the only one that reaches sticky fields
        if (!fundRstN)
        begin
            fundSync_q <= 2'h0;
        end
        else
        begin
            fundSync_q <= {fundSync_q[0], 1'b1};
        end
    end


    // sticky control fields and counter
    reg checkDis_q;
    reg injEn_q;
    reg [7:0] matchLen_q;
    reg [7:0] errCount_q;
    // non-sticky state
    reg errFlag_q;
    reg [1:0] rptSel_q;
    reg [`PEP_IRQ_W-1:0] irqSts_q;
    reg [`PEP_IRQ_W-1:0] irqMask_q;
    reg injTlp_q;
    reg ack_q;

    // bus decode helpers
    function isAddr;
        input [11:0] a;
        input [11:0] b;
        begin
            isAddr = (a[11:2] == b[11:2]);
        end
    endfunction

    wire req = avs_read | avs_write;
    // one wait cycle per access, then acknowledge
    assign avs_waitrequest = req & ~ack_q;
    wire wrDo = avs_write & ack_q;
    wire rdDo = avs_read & ack_q;
    wire be0 = avs_byteenable[0];
    wire be1 = avs_byteenable[1];

    always @(posedge clk or negedge rstN)
    begin
        // drops after one cycle so a held read clears the counter only on every second cycle
        if (!rstN)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end


    // transmit path: tag whole TLP at its first word
    wire sopMatch = txSop & injEn_q & (txData[7:0] == matchLen_q);
    wire injNow = txSop ? sopMatch : injTlp_q;

    always @(posedge clk or negedge rstN)
    begin
        // decision held until the next first word; no per-word length decode
        if (!rstN)
        begin
            injTlp_q <= 1'b0;
        end
        else if (txValid & txSop)
        begin
            injTlp_q <= sopMatch;
        end
    end


    // parity is generated unconditionally; inject only flips it
    pep_parity_gen #(.DW(DW)) txGen
    (
        .clk(clk),
        .rstN(rstN),
        .inValid(txValid),
        .inData(txData),
        .corrupt(txValid & injNow),
        .outValid(coreValid),
        .outData(coreData),
        .outPar(corePar)
    );

    // receive check: even parity per byte lane
    wire [DW/8-1:0] rxBad;
    genvar g;
    generate
        for (g = 0; g < DW/8; g = g + 1)
        begin : chk
            assign rxBad[g] = ^rxData[g*8+7:g*8] ^ rxPar[g];
        end
    endgenerate

    wire parErr = rxValid & ~checkDis_q & (|rxBad);

    // status flag, set beats a same-cycle clear
    wire flagClr = wrDo & isAddr(avs_address, `PEP_ADDR_STS) & be0
        & avs_writedata[`PEP_STS_FLAG_BIT];
    wire flagRise = parErr & ~errFlag_q;

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            errFlag_q <= 1'b0;
        end
        else if (parErr)
        begin
            errFlag_q <= 1'b1;
        end
        else if (flagClr)
        begin
            errFlag_q <= 1'b0;
        end
    end


    // error message to the root, one pulse per zero-to-one of the status flag, none while reporting is none
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            errMsgValid <= 1'b0;
            errMsgType <= `PEP_MSG_NONE;
        end
        else
        begin
            errMsgValid <= flagRise & (rptSel_q != `PEP_MSG_NONE);
            errMsgType <= rptSel_q;
        end
    end

    // reporting select, non-sticky
    always @(posedge clk or negedge rstN)
    begin
        // a hot reset puts reporting back to non-fatal
        if (!rstN)
        begin
            rptSel_q <= `PEP_RPT_RESET;
        end
        else if (wrDo & isAddr(avs_address, `PEP_ADDR_RPT) & be0)
        begin
            rptSel_q <= avs_writedata[1:0];
        end
    end


    // sticky control fields, only fundamental reset clears them
    always @(posedge clk or negedge fundN)
    begin
        if (!fundN)
        begin
            checkDis_q <= 1'b0;
            injEn_q <= 1'b0;
            matchLen_q <= 8'h00;
        end
        else if (wrDo & isAddr(avs_address, `PEP_ADDR_CTL))
        begin
            if (be0)
            begin
                checkDis_q <= avs_writedata[`PEP_CTL_DIS_BIT];
                injEn_q <= avs_writedata[`PEP_CTL_INJ_BIT];
            end
            if (be1)
            begin
                matchLen_q <= avs_writedata[`PEP_CTL_LEN_HI:`PEP_CTL_LEN_LO];
            end
        end
    end

    // counter: an error in the read cycle counts after the clear
    wire cntRead = rdDo & isAddr(avs_address, `PEP_ADDR_CNT);
    wire cntSat = (errCount_q == `PEP_CNT_MAX);

    always @(posedge clk or negedge fundN)
    begin
        // an error landing on the read is kept, not lost to the clear
        if (!fundN)
        begin
            errCount_q <= 8'h00;
        end
        else if (cntRead)
        begin
            errCount_q <= parErr ? 8'h01 : 8'h00;
        end
        else if (parErr & ~cntSat)
        begin
            errCount_q <= errCount_q + 8'h01;
        end
    end


    // interrupt status: error seen, counter reached saturation
    wire [`PEP_IRQ_W-1:0] irqEv;
    assign irqEv[`PEP_IRQ_ERR_BIT] = parErr;
    assign irqEv[`PEP_IRQ_SAT_BIT] = parErr & ~cntRead & (errCount_q == 8'hFE);
    wire [`PEP_IRQ_W-1:0] irqClr = (wrDo & isAddr(avs_address, `PEP_ADDR_IRQ_STS) & be0)
        ? avs_writedata[`PEP_IRQ_W-1:0] : {`PEP_IRQ_W{1'b0}};

    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            irqSts_q <= {`PEP_IRQ_W{1'b0}};
            irqMask_q <= {`PEP_IRQ_W{1'b0}};
        end
        else
        begin
            irqSts_q <= (irqSts_q & ~irqClr) | irqEv; // set wins
            if (wrDo & isAddr(avs_address, `PEP_ADDR_IRQ_MASK) & be0)
            begin
                irqMask_q <= avs_writedata[`PEP_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irqSts_q & irqMask_q);

    // read mux, unmapped reads zero with error response
    reg [31:0] rdMux;
    reg rdHit;

    always @*
    begin
        rdMux = 32'h0;
        rdHit = 1'b1;
        // reserved bits read as zero in every register
        if (isAddr(avs_address, `PEP_ADDR_CTL))
        begin
            rdMux = {16'h0, matchLen_q, 6'h0, injEn_q, checkDis_q};
        end
        else if (isAddr(avs_address, `PEP_ADDR_STS))
        begin
            rdMux = {31'h0, errFlag_q};
        end
        else if (isAddr(avs_address, `PEP_ADDR_RPT))
        begin
            rdMux = {30'h0, rptSel_q};
        end
        else if (isAddr(avs_address, `PEP_ADDR_CNT))
        begin
            rdMux = {24'h0, errCount_q};
        end
        else if (isAddr(avs_address, `PEP_ADDR_IRQ_STS))
        begin
            rdMux = {{(32-`PEP_IRQ_W){1'b0}}, irqSts_q};
        end
        else if (isAddr(avs_address, `PEP_ADDR_IRQ_MASK))
        begin
            rdMux = {{(32-`PEP_IRQ_W){1'b0}}, irqMask_q};
        end
        else
        begin
            rdHit = 1'b0;
        end
    end


    // read data valid only at the acknowledge edge; captured the cycle before
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            avs_readdata <= 32'h0;
            avs_response <= 1'b0;
        end
        else if (req & ~ack_q)
        begin
            avs_readdata <= avs_read ? rdMux : 32'h0;
            avs_response <= ~rdHit;
        end
    end
endmodule

/* testbench/pep_chk.sv */
// Purpose: port checks for the parity unit
// Assumes: word width of 32
// Notes: bound below
module pep_chk
#(
    parameter DW = 32
)
(
    input wire clk,
    input wire rst_n,
    input wire fundRstN,
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire avs_waitrequest,
    input wire avs_response,
    input wire txValid,
    input wire coreValid,
    input wire [DW-1:0] coreData,
    input wire [DW/8-1:0] corePar,
    input wire rxValid,
    input wire errMsgValid,
    input wire [1:0] errMsgType
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !fundRstN);
    logic dis_q = 1'b0;
    wire [3:0] ev = {^coreData[31:24], ^coreData[23:16], ^coreData[15:8], ^coreData[7:0]};
    // mirror of the check-disable bit; sticky, so only fundamental reset clears it
    always @(posedge clk or negedge fundRstN)
    begin
        if (!fundRstN)
            dis_q <= 1'b0;
        else if (avs_write && !avs_waitrequest && avs_address == 12'h740 && avs_byteenable[0])
            dis_q <= avs_writedata[0];
    end
    property p_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus wait cycle wrong");
    property p_core;
        txValid |=> coreValid;
    endproperty
    a_core: assert property (p_core) else $error("word not forwarded");
    property p_par;
        coreValid |-> corePar == ev || corePar == ~ev;
    endproperty
    a_par: assert property (p_par) else $error("core parity wrong");
    property p_dis;
        rxValid && dis_q |=> !errMsgValid;
    endproperty
    a_dis: assert property (p_dis) else $error("message while disabled");
    property p_type;
        errMsgValid |-> errMsgType != 2'h0;
    endproperty
    a_type: assert property (p_type) else $error("message of type none");
    property p_once;
        errMsgValid |=> !errMsgValid;
    endproperty
    a_once: assert property (p_once) else $error("message repeated");
    property p_cause;
        errMsgValid |-> $past(rxValid);
    endproperty
    a_cause: assert property (p_cause) else $error("message without word");
    property p_resp;
        avs_read && !avs_waitrequest && avs_address == 12'h7F0 |-> avs_response;
    endproperty
    a_resp: assert property (p_resp) else $error("unmapped read accepted");
    c_fatal: cover property (errMsgValid && errMsgType == 2'h3);
    c_dis: cover property (rxValid && dis_q);
    c_resp: cover property (avs_response);
endmodule
bind pep_parity_unit pep_chk #(.DW(DW)) i_chk (.clk(clk), .rst_n(rst_n),
    .fundRstN(fundRstN), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .txValid(txValid),
    .coreValid(coreValid), .coreData(coreData), .corePar(corePar), .rxValid(rxValid),
    .errMsgValid(errMsgValid), .errMsgType(errMsgType));

/* testbench/pep_core_model.sv */
// Purpose: switch core echoing port words back for checking
// Assumes: one word a cycle, no backpressure
// Notes: idle lines toggle every cycle, starting from the inverse of the last word
module pep_core_model
(
    input wire clk,
    input wire inValid,
    input wire [31:0] inData,
    input wire [3:0] inPar,
    output logic outValid = 1'b0,
    output logic [31:0] outData = 32'h0,
    output logic [3:0] outPar = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // echo one cycle later; toggling idle lines so stale data never matches
    always @(posedge clk)
    begin
        outValid <= inValid;
        outData <= inValid ? inData : ~outData;
        outPar <= inValid ? inPar : ~outPar;
    end
endmodule

/* testbench/tb.sv */
// Purpose: register and stream tests of the parity unit
// Assumes: core model echoes forwarded words back
// Notes: injection is the only source of bad parity
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstN = 0, fundRstN = 0, rdReq = 0, wrReq = 0, txV = 0, txS = 0, rs;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, txD = 32'h0, rv;
    wire wq, resp, cV, rV, mV, irq;
    wire [31:0] rdat, cD, rD;
    wire [3:0] cP, rP;
    wire [1:0] mT;
    int error_cnt = 0, n_checks = 0, msgN = 0;
    logic [1:0] lastT = 2'h0;
    pep_parity_unit #(.DW(32)) i_dut (.clk(clk), .rst_n(rstN), .fundRstN(fundRstN),
        .avs_address(adr), .avs_read(rdReq), .avs_write(wrReq), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_waitrequest(wq), .avs_readdata(rdat),
        .avs_response(resp), .txValid(txV), .txSop(txS), .txData(txD), .coreValid(cV),
        .coreData(cD), .corePar(cP), .rxValid(rV), .rxData(rD), .rxPar(rP),
        .errMsgValid(mV), .errMsgType(mT), .irq(irq));
    pep_core_model i_core (.clk(clk), .inValid(cV), .inData(cD), .inPar(cP),
        .outValid(rV), .outData(rD), .outPar(rP));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // tally messages toward the root
    always @(posedge clk)
    begin
        if (mV === 1'b1)
        begin
            msgN++;
            lastT = mT;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wrReq <= w;
        rdReq <= !w;
        @(posedge clk);
        while (wq !== 1'b0)
            @(posedge clk);
        rv = rdat;
        rs = resp;
        wrReq <= 0;
        rdReq <= 0;
    endtask
    task automatic wrr(input logic [11:0] a, input logic [31:0] d);
        acc(1, a, d);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        acc(0, a, 0);
        chk(rv, e);
    endtask
    // one packet; byte zero of the first word is the length field
    task automatic tlp(input logic [7:0] len, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            txV <= 1;
            txS <= (i == 0);
            txD <= {8'hA5, i[15:0], len};
        end
        @(posedge clk);
        txV <= 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic rst(input logic fund);
        @(posedge clk);
        rstN <= 0;
        if (fund)
            fundRstN <= 0;
        repeat (5) @(posedge clk);
        rstN <= 1;
        fundRstN <= 1;
        repeat (3) @(posedge clk);
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200us;
        error_cnt++;
        end_sim;
    end
    initial
    begin
        int m;
        rst(1);
        rc(12'h740, 0);
        rc(12'h744, 0);
        rc(12'h748, 2);
        rc(12'h74C, 0);
        rc(12'h7F0, 0);
        chk(rs, 1);
        tlp(8'h05, 3);
        rc(12'h744, 0);
        wrr(12'h740, 32'h0502);
        tlp(8'h04, 2);
        rc(12'h74C, 0);
        tlp(8'h05, 3);
        rc(12'h744, 1);
        chk(msgN, 1);
        chk(lastT, 2);
        rc(12'h74C, 3);
        rc(12'h74C, 0);
        wrr(12'h744, 0);
        rc(12'h744, 1);
        // every reporting code, each after a fresh zero-to-one of the flag
        for (int c = 0; c < 4; c++)
        begin
            wrr(12'h744, 1);
            wrr(12'h748, c);
            m = msgN;
            tlp(8'h05, 1);
            chk(msgN - m, c != 0);
            if (c != 0)
                chk(lastT, c);
        end
        rc(12'h74C, 4);
        wrr(12'h744, 1);
        wrr(12'h740, 32'h0503);
        tlp(8'h05, 2);
        rc(12'h744, 0);
        rc(12'h74C, 0);
        wrr(12'h740, 32'h0502);
        tlp(8'h05, 260);
        rc(12'h74C, 32'hFF);
        #1 chk(irq, 0);
        wrr(12'h764, 1);
        #1 chk(irq, 1);
        wrr(12'h760, 3);
        #1 chk(irq, 0);
        tlp(8'h05, 2);
        rst(0);
        rc(12'h740, 32'h0502);
        rc(12'h748, 2);
        rc(12'h74C, 2);
        rst(1);
        rc(12'h740, 0);
        end_sim;
    end
endmodule
